// *** fpe_arr_if.sv ***
`timescale 1ns/1ps
interface fpe_arr_if;
   logic        we;
   logic [12:0] waddr;
   logic [7:0]  wdata;
   logic        re;
   logic [12:0] raddr;
   logic [7:0]  rdata;
   logic [7:0]  lock_byte;

   modport ctl (output we, waddr, wdata, re, raddr, input rdata, lock_byte);
   modport mem (input we, waddr, wdata, re, raddr, output rdata, lock_byte);
endinterface

// *** fpe_array.sv ***
`timescale 1ns/1ps
module fpe_array #(
   parameter int unsigned DEPTH = fpe_pkg::ARRAY_BYTES
) (
   input  wire logic i_clk,
   fpe_arr_if.mem    arr
);
   import fpe_pkg::*;

   logic [7:0] mem [DEPTH];
   logic [7:0] rdata_r;

   // Blank array at start of simulation, as an erased part
   initial begin
      for (int i = 0; i < int'(DEPTH); i++) begin
         mem[i] = ERASED;
      end
   end

   // One write port, one registered read port
   always_ff @(posedge i_clk) begin
      if (arr.we) begin
         mem[arr.waddr] <= arr.wdata;
      end
      if (arr.re) begin
         rdata_r <= mem[arr.raddr];
      end
   end

   assign arr.rdata = rdata_r;
   // Security byte is watched all the time, so it needs its own tap
   assign arr.lock_byte = mem[LOCK_ADDR];
endmodule

// *** fpe_cpu_model.sv ***
`timescale 1ns/1ps
module fpe_cpu_model (
   input  wire logic        i_clk,
   input  wire logic        i_stall,
   input  wire logic        i_cr_ack,
   input  wire logic [7:0]  i_cr_data,
   output logic             o_xw_valid,
   output logic [15:0]      o_xw_addr,
   output logic [7:0]       o_xw_data,
   output logic             o_cr_valid,
   output logic             o_cr_fetch,
   output logic [15:0]      o_cr_addr,
   output logic [15:0]      o_pc
);
   // Quiet bus at time zero
   initial begin
      o_xw_valid = 1'b0;
      o_xw_addr = 16'h0;
      o_xw_data = 8'h0;
      o_cr_valid = 1'b0;
      o_cr_fetch = 1'b0;
      o_cr_addr = 16'h0;
      o_pc = 16'h0;
   end
   // Write move; core sits still while stalled and reports the stall length
   task automatic xw(input logic [15:0] a, input logic [7:0] d, output int n);
      @(posedge i_clk);
      o_xw_valid <= 1'b1;
      o_xw_addr <= a;
      o_xw_data <= d;
      @(posedge i_clk);
      o_xw_valid <= 1'b0;
      o_xw_addr <= ~a; // Released lines must not hold old value
      o_xw_data <= ~d;
      @(negedge i_clk);
      n = 0;
      while (i_stall === 1'b1) begin
         n++;
         @(negedge i_clk);
      end
   endtask
   // Code read move or fetch from code running at p
   task automatic cr(input logic f, input logic [15:0] a, input logic [15:0] p, output logic ack,
                     output logic [7:0] d);
      @(posedge i_clk);
      o_cr_valid <= 1'b1;
      o_cr_fetch <= f;
      o_cr_addr <= a;
      o_pc <= p;
      @(posedge i_clk);
      o_cr_valid <= 1'b0;
      o_cr_addr <= ~a;
      @(negedge i_clk);
      ack = i_cr_ack;
      d = i_cr_data;
   endtask
endmodule

// *** fpe_ctrl.sv ***
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module fpe_ctrl #(
   parameter int unsigned ERASE_CYCLES = fpe_pkg::ERASE_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Register bus
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   // CPU write move
   input  wire logic        i_xw_valid,
   input  wire logic [15:0] i_xw_addr,
   input  wire logic [7:0]  i_xw_data,
   output logic             o_ram_we,
   output logic [15:0]      o_ram_addr,
   output logic [7:0]       o_ram_wdata,
   // CPU code read move and fetch
   input  wire logic        i_cr_valid,
   input  wire logic        i_cr_fetch,
   input  wire logic [15:0] i_cr_addr,
   input  wire logic [15:0] i_pc,
   output logic             o_cr_ack,
   output logic [7:0]       o_cr_data,
   // Two-wire debug port byte access
   input  wire logic        i_dbg_valid,
   input  wire logic        i_dbg_erase,
   input  wire logic [15:0] i_dbg_addr,
   input  wire logic [7:0]  i_dbg_data,
   output logic             o_dbg_err,
   // System side
   output logic             o_stall,
   output logic             o_mem_err_rst
);
   import fpe_pkg::*;

   typedef struct packed {
      fpe_key_e                 ks;
      logic                     program_write_enable;
      logic                     page_erase_enable;
      logic                     merr;
      logic                     rst_req;
      fpe_op_e                  op;
      logic                     src_cpu;
      logic [CNT_W-1:0]         cnt;
      logic [AW-1:0]            addr;
      logic [7:0]               data;
      logic                     hwr;
      logic [7:0]               hadr;
      logic [31:0]              hrdata;
      logic                     hrdy;
      logic                     ram_we;
      logic [15:0]              ram_addr;
      logic [7:0]               ram_data;
      logic                     cr_ack;
      logic                     dbg_err;
      logic                     stall;
   } fpe_state_s;

   fpe_state_s s_r;
   fpe_state_s s_nxt;

   fpe_arr_if arr ();

   logic idle;
   logic acc;
   logic err;

   // Page locked by the security byte; its own page only when others are
   function automatic logic pg_locked(input logic [3:0] pg,
                                      input logic [7:0] lb);
      if (pg == LOCK_PAGE) begin
         pg_locked = (lb != ERASED);
      end else begin
         pg_locked = ({4'h0, pg} < ~lb);
      end
   endfunction

   // Firmware access check: range first, then page locking
   function automatic logic viol(input logic [15:0] a,
                                 input logic [1:0]  k,
                                 input logic [15:0] pc,
                                 input logic [7:0]  lb);
      logic [3:0] pg;
      pg = a[12:9];
      if (a > USER_TOP) begin
         viol = 1'b1;
      end else if (k == ACC_ERASE && pg == LOCK_PAGE) begin
         viol = 1'b1;
      end else if (k == ACC_READ && a[AW-1:0] == LOCK_ADDR) begin
         viol = 1'b0;
      end else if (pg_locked(pc[12:9], lb)) begin
         viol = 1'b0;
      end else begin
         viol = pg_locked(pg, lb);
      end
   endfunction

   // Readback of one register word
   function automatic logic [31:0] rd_word(input logic [7:0] ofs,
                                           input fpe_state_s st);
      case (ofs)
         PSC_OFS: rd_word = (32'(st.page_erase_enable) << PAGE_ERASE_ENABLE_BIT) | (32'(st.program_write_enable) << PROGRAM_WRITE_ENABLE_BIT);
         KEY_OFS: rd_word = {30'h0, st.ks};
         RSS_OFS: rd_word = 32'(st.merr) << MERR_BIT;
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction

   assign idle = (s_r.op == OP_IDLE) && !s_r.rst_req;
   assign acc  = i_hsel && i_htrans[1] && i_hready;
   assign err  = viol(i_xw_addr, s_r.page_erase_enable ? ACC_ERASE : ACC_WRITE, i_pc, arr.lock_byte);

   // Next-state logic for registers, key, sequencer and error reset
   always_comb begin
      s_nxt = s_r;
      s_nxt.ram_we  = 1'b0;
      s_nxt.cr_ack  = 1'b0;
      s_nxt.dbg_err = 1'b0;
      s_nxt.hwr     = 1'b0;
      arr.we    = 1'b0;
      arr.waddr = s_r.addr;
      arr.wdata = ERASED;
      arr.re    = 1'b0;
      arr.raddr = i_cr_addr[AW-1:0];

      // Bus data phase: the write lands here
      if (s_r.hwr) begin
         case (s_r.hadr)
            PSC_OFS: begin
               s_nxt.program_write_enable = i_hwdata[PROGRAM_WRITE_ENABLE_BIT];
               s_nxt.page_erase_enable = i_hwdata[PAGE_ERASE_ENABLE_BIT];
            end
            KEY_OFS: begin
               case (s_r.ks)
                  KS_LOCKED: begin
                     s_nxt.ks = (i_hwdata[7:0] == KEY_FIRST) ? KS_FIRST : KS_DEAD;
                  end
                  KS_FIRST: begin
                     s_nxt.ks = (i_hwdata[7:0] == KEY_SECOND) ? KS_OPEN : KS_DEAD;
                  end
                  default: begin
                     s_nxt.ks = KS_DEAD;
                  end
               endcase
            end
            default: begin
            end
         endcase
      end

      // Bus address phase; read sees the write just applied
      if (acc && i_hwrite) begin
         s_nxt.hwr  = 1'b1;
         s_nxt.hadr = i_haddr[7:0];
      end
      if (acc && !i_hwrite) begin
         s_nxt.hrdata = rd_word(i_haddr[7:0], s_nxt);
      end

      // Operation sequencer
      case (s_r.op)
         OP_IDLE: begin
            if (!idle) begin
               // Error reset pending, hold everything
            end else if (i_xw_valid && !s_r.program_write_enable) begin
               s_nxt.ram_we   = 1'b1;
               s_nxt.ram_addr = i_xw_addr;
               s_nxt.ram_data = i_xw_data;
            end else if (i_xw_valid) begin
               if (err) begin
                  s_nxt.rst_req = 1'b1;
               end else if (s_r.ks != KS_OPEN) begin
                  s_nxt.ks = KS_DEAD;
               end else begin
                  s_nxt.src_cpu = 1'b1;
                  s_nxt.addr    = i_xw_addr[AW-1:0];
                  s_nxt.data    = i_xw_data;
                  s_nxt.stall   = 1'b1;
                  arr.re        = 1'b1;
                  arr.raddr     = i_xw_addr[AW-1:0];
                  if (s_r.page_erase_enable) begin
                     s_nxt.op  = OP_ERASE;
                     s_nxt.cnt = CNT_W'(ERASE_CYCLES - 1);
                  end else begin
                     s_nxt.op  = OP_PROG;
                     s_nxt.cnt = CNT_W'(WR_CYC - 1);
                  end
               end
            end else if (i_cr_valid) begin
               if (i_cr_fetch ? (i_cr_addr > USER_TOP)
                              : viol(i_cr_addr, ACC_READ, i_pc, arr.lock_byte)) begin
                  s_nxt.rst_req = 1'b1;
               end else begin
                  arr.re       = 1'b1;
                  s_nxt.cr_ack = 1'b1;
               end
            end else if (i_dbg_valid) begin
               if (i_dbg_addr > USER_TOP || pg_locked(i_dbg_addr[12:9], arr.lock_byte)) begin
                  s_nxt.dbg_err = 1'b1;
               end else begin
                  s_nxt.src_cpu = 1'b0;
                  s_nxt.addr    = i_dbg_addr[AW-1:0];
                  s_nxt.data    = i_dbg_data;
                  s_nxt.stall   = 1'b1;
                  arr.re        = 1'b1;
                  arr.raddr     = i_dbg_addr[AW-1:0];
                  if (i_dbg_erase) begin
                     s_nxt.op  = OP_ERASE;
                     s_nxt.cnt = CNT_W'(ERASE_CYCLES - 1);
                  end else begin
                     s_nxt.op  = OP_PROG;
                     s_nxt.cnt = CNT_W'(WR_CYC - 1);
                  end
               end
            end
         end
         OP_PROG: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            if (s_r.cnt == '0) begin
               arr.we    = 1'b1;
               arr.wdata = arr.rdata & s_r.data;
            end
         end
         OP_ERASE: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            // Page is cleared over its last 512 cycles; data byte unused
            if (s_r.cnt < CNT_W'(ARRAY_BYTES / 16)) begin
               arr.we    = 1'b1;
               arr.waddr = {s_r.addr[AW-1:PAGE_W], s_r.cnt[PAGE_W-1:0]};
               arr.wdata = ERASED;
            end
         end
         default: begin
            s_nxt.op = OP_IDLE;
         end
      endcase

      // End of a timed operation releases the CPU
      if (s_r.op != OP_IDLE && s_r.cnt == '0) begin
         s_nxt.op    = OP_IDLE;
         s_nxt.stall = 1'b0;
         if (s_r.src_cpu && s_nxt.ks != KS_DEAD) begin
            s_nxt.ks = KS_LOCKED;
         end
      end

      // Any system reset; error flag records whether we caused it
      if (i_rst) begin
         s_nxt      = '0;
         s_nxt.ks   = KS_LOCKED;
         s_nxt.op   = OP_IDLE;
         s_nxt.hrdy = 1'b1;
         s_nxt.merr = s_r.rst_req;
      end
   end

   // Single state register
   always_ff @(posedge i_clk) begin
      s_r <= s_nxt;
   end

   fpe_array u_array (
      .i_clk (i_clk),
      .arr   (arr.mem)
   );

   // Outputs straight from flops; response is always OKAY
   assign o_hreadyout   = s_r.hrdy;
   assign o_hresp       = 1'b0;
   assign o_hrdata      = s_r.hrdata;
   assign o_ram_we      = s_r.ram_we;
   assign o_ram_addr    = s_r.ram_addr;
   assign o_ram_wdata   = s_r.ram_data;
   assign o_cr_ack      = s_r.cr_ack;
   assign o_cr_data     = arr.rdata;
   assign o_dbg_err     = s_r.dbg_err;
   assign o_stall       = s_r.stall;
   assign o_mem_err_rst = s_r.rst_req;
endmodule

// *** fpe_ctrl_asserts.sv ***
`timescale 1ns/1ps
module fpe_ctrl_asserts #(
   parameter int unsigned ERASE_CYCLES = 600
) (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_xw_valid,
   input wire logic [15:0] i_xw_addr,
   input wire logic [7:0]  i_xw_data,
   input wire logic        i_cr_valid,
   input wire logic [15:0] i_cr_addr,
   input wire logic        o_hreadyout,
   input wire logic        o_hresp,
   input wire logic        o_ram_we,
   input wire logic [15:0] o_ram_addr,
   input wire logic [7:0]  o_ram_wdata,
   input wire logic        o_cr_ack,
   input wire logic        o_stall,
   input wire logic        o_mem_err_rst
);
   logic [19:0] stall_len_r;
   logic        idle;
   // Stall length so far, judged on the falling edge of the stall
   always_ff @(posedge i_clk) begin
      if (i_rst || !o_stall) begin
         stall_len_r <= 20'h0;
      end else begin
         stall_len_r <= stall_len_r + 20'h1;
      end
   end
   // Free to take a code read this cycle
   assign idle = !i_xw_valid && !o_stall && !o_mem_err_rst;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_bus_okay; o_hreadyout && !o_hresp; endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready okay");
   property p_stall_len; $fell(o_stall) |-> stall_len_r == 20'h898 || stall_len_r == 20'(ERASE_CYCLES); endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   property p_err_hold; o_mem_err_rst |=> o_mem_err_rst; endproperty
   a_err_hold: assert property (p_err_hold) else $error("error reset request dropped");
   property p_err_quiet; o_mem_err_rst |-> !o_stall && !o_ram_we && !o_cr_ack; endproperty
   a_err_quiet: assert property (p_err_quiet) else $error("access done during error reset");
   property p_stall_quiet; o_stall |-> !o_ram_we && !o_cr_ack && !o_mem_err_rst; endproperty
   a_stall_quiet: assert property (p_stall_quiet) else $error("activity during stall");
   property p_read_range; i_cr_valid && idle && i_cr_addr > 16'h1dff |=> o_mem_err_rst && !o_cr_ack; endproperty
   a_read_range: assert property (p_read_range) else $error("high code read not refused");
   property p_lock_byte; i_cr_valid && idle && i_cr_addr == 16'h1dff |=> o_cr_ack && !o_mem_err_rst; endproperty
   a_lock_byte: assert property (p_lock_byte) else $error("lock byte read refused");
   property p_ram_steer;
      o_ram_we |-> $past(i_xw_valid) && o_ram_addr == $past(i_xw_addr) && o_ram_wdata == $past(i_xw_data);
   endproperty
   a_ram_steer: assert property (p_ram_steer) else $error("data RAM write mismatch");
endmodule

bind fpe_ctrl fpe_ctrl_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_xw_valid(i_xw_valid), .i_xw_addr(i_xw_addr), .i_xw_data(i_xw_data), .i_cr_valid(i_cr_valid),
   .i_cr_addr(i_cr_addr), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_ram_we(o_ram_we),
   .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata), .o_cr_ack(o_cr_ack), .o_stall(o_stall),
   .o_mem_err_rst(o_mem_err_rst));

// *** fpe_ctrl_bench.sv ***
`timescale 1ns/1ps
module fpe_ctrl_bench;
   import fpe_pkg::*;
   localparam int unsigned ERASE_N = 600;
   logic        clk, rst, hsel, hwrite, hrdy, hresp, ram_we, xw_v, cr_v, cr_f, ack, mem_err;
   logic        stall;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [15:0] ram_addr, xw_a, cr_a, pc;
   logic [7:0]  ram_d, xw_d, cr_d, d;
   logic        dbg_v, dbg_e, dbg_err;
   logic [15:0] dbg_a;
   logic [7:0]  dbg_dt;
   int          errors, samples_checked, n;
   fpe_ctrl #(.ERASE_CYCLES(ERASE_N)) dut_u (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_xw_valid(xw_v), .i_xw_addr(xw_a),
      .i_xw_data(xw_d), .o_ram_we(ram_we), .o_ram_addr(ram_addr), .o_ram_wdata(ram_d), .i_cr_valid(cr_v),
      .i_cr_fetch(cr_f), .i_cr_addr(cr_a), .i_pc(pc), .o_cr_ack(ack), .o_cr_data(cr_d), .i_dbg_valid(dbg_v),
      .i_dbg_erase(dbg_e), .i_dbg_addr(dbg_a), .i_dbg_data(dbg_dt), .o_dbg_err(dbg_err), .o_stall(stall),
      .o_mem_err_rst(mem_err));
   fpe_cpu_model cpu_u (.i_clk(clk), .i_stall(stall), .i_cr_ack(ack), .i_cr_data(cr_d), .o_xw_valid(xw_v),
      .o_xw_addr(xw_a), .o_xw_data(xw_d), .o_cr_valid(cr_v), .o_cr_fetch(cr_f), .o_cr_addr(cr_a), .o_pc(pc));
   always #12.5 clk = ~clk;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Single AHB-Lite word transfer, waits out the slave's ready
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      logic [31:0] rd;
      ahb(1'b1, a, {24'h0, v}, rd);
   endtask
   task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      ahb(1'b0, a, 32'h0, rd);
      chk(what, rd, exp);
   endtask
   task automatic keys;
      wreg(KEY_OFS, KEY_FIRST);
      wreg(KEY_OFS, KEY_SECOND);
   endtask
   // Mid-run resets last one edge, so the error flag is captured at that edge
   task automatic do_reset(input int cyc = 1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (cyc) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      rreg("key", KEY_OFS, 32'h0);
      rreg("psc", PSC_OFS, 32'h0);
      rreg("rss", RSS_OFS, 32'h0);
      wreg(PSC_OFS, 8'h03);
      rreg("psc", PSC_OFS, 32'h3);
      rreg("unmapped", 8'h0c, 32'h0);
      wreg(PSC_OFS, 8'h00);
      wreg(KEY_OFS, KEY_FIRST);
      rreg("key", KEY_OFS, 32'h1);
      wreg(KEY_OFS, KEY_SECOND);
      rreg("key", KEY_OFS, 32'h2);
      do_reset();
   endtask
   task automatic t_ram;
      cpu_u.xw(16'h0100, 8'h5a, n);
      chk("ram_we", 32'(ram_we), 32'h1);
      chk("ram_addr", 32'(ram_addr), 32'h100);
      chk("ram_data", 32'(ram_d), 32'h5a);
      chk("ram_stall", 32'(n), 32'h0);
   endtask
   task automatic t_program;
      wreg(PSC_OFS, 8'h01);
      keys();
      cpu_u.xw(16'h0010, 8'h3c, n);
      chk("prog_stall", 32'(n), 32'h898);
      rreg("key", KEY_OFS, 32'h0);
      keys();
      cpu_u.xw(16'h0010, 8'hf0, n);
      cpu_u.cr(1'b0, 16'h0010, 16'h0, ack, d);
      chk("and_byte", 32'(d), 32'h30);
      cpu_u.cr(1'b0, 16'h0011, 16'h0, ack, d);
      chk("neighbour", 32'(d), 32'hff);
      wreg(PSC_OFS, 8'h02);
      wreg(PSC_OFS, 8'h03);
      keys();
      cpu_u.xw(16'h01f0, 8'h00, n);
      chk("erase_stall", 32'(n), 32'(ERASE_N));
      wreg(PSC_OFS, 8'h00);
      cpu_u.cr(1'b0, 16'h0010, 16'h0, ack, d);
      chk("erased", 32'(d), 32'hff);
      chk("read_ack", 32'(ack), 32'h1);
   endtask
   task automatic t_lockout;
      logic [7:0] bad [2];
      bad = '{8'hf1, 8'h5a};
      foreach (bad[i]) begin
         wreg(PSC_OFS, 8'h01);
         wreg(KEY_OFS, bad[i]);
         rreg("key_dead", KEY_OFS, 32'h3);
         keys();
         cpu_u.xw(16'h0020, 8'h00, n);
         chk("dead_stall", 32'(n + int'(ram_we)), 32'h0);
         rreg("key_dead", KEY_OFS, 32'h3);
         do_reset();
         rreg("key_reset", KEY_OFS, 32'h0);
      end
      wreg(PSC_OFS, 8'h01);
      cpu_u.xw(16'h0020, 8'h00, n);
      rreg("key_early", KEY_OFS, 32'h3);
      cpu_u.cr(1'b0, 16'h0020, 16'h0, ack, d);
      chk("untouched", 32'(d), 32'hff);
      do_reset();
   endtask
   // Debug-port byte program, then a refused reserved-area request
   task automatic t_debug;
      @(posedge clk);
      dbg_v <= 1'b1;
      dbg_e <= 1'b0;
      dbg_a <= 16'h0030;
      dbg_dt <= 8'h12;
      @(posedge clk);
      dbg_v <= 1'b0;
      @(negedge clk);
      chk("dbg_stall", 32'(stall), 32'h1);
      while (stall === 1'b1) @(negedge clk);
      cpu_u.cr(1'b0, 16'h0030, 16'h0, ack, d);
      chk("dbg_byte", 32'(d), 32'h12);
      @(posedge clk);
      dbg_v <= 1'b1;
      dbg_a <= 16'h1e00;
      @(posedge clk);
      dbg_v <= 1'b0;
      @(negedge clk);
      chk("dbg_err", 32'(dbg_err), 32'h1);
      chk("dbg_nostall", 32'(stall), 32'h0);
   endtask
   task automatic t_memerr;
      logic [15:0] at [3];
      at = '{16'h1e00, 16'h1e00, 16'h1fff};
      foreach (at[i]) begin
         if (i == 0) begin
            wreg(PSC_OFS, 8'h01);
            cpu_u.xw(at[i], 8'h00, n);
         end else begin
            cpu_u.cr(i == 2, at[i], 16'h0, ack, d);
         end
         chk("err_rst", 32'(mem_err), 32'h1);
         do_reset();
         rreg("rss_flag", RSS_OFS, 32'h40);
      end
      wreg(PSC_OFS, 8'h01);
      keys();
      cpu_u.xw(16'h1dff, 8'hfe, n);
      wreg(PSC_OFS, 8'h00);
      cpu_u.cr(1'b0, 16'h0010, 16'h0800, ack, d);
      chk("lock_err", 32'(mem_err), 32'h1);
      do_reset();
      cpu_u.cr(1'b0, 16'h1dff, 16'h0800, ack, d);
      chk("lock_byte", 32'({ack, d}), 32'h1fe);
   endtask
   task automatic complete_run;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      dbg_v = 1'b0;
      dbg_e = 1'b0;
      dbg_a = 16'h0;
      dbg_dt = 8'h0;
      errors = 0;
      samples_checked = 0;
      do_reset(10);
      t_regs();
      t_ram();
      t_program();
      t_lockout();
      t_debug();
      t_memerr();
      complete_run();
   end
   // Watchdog, about four times the expected run
   initial begin
      #(25.0 * 40000);
      errors++;
      complete_run();
   end
endmodule

// *** fpe_pkg.sv ***
package fpe_pkg;

   // System clock and operation times
   localparam int unsigned CLK_MHZ       = 40;
   localparam int unsigned WR_TIME_US    = 55;
   localparam int unsigned ERASE_TIME_MS = 15;
   localparam int unsigned WR_CYC        = WR_TIME_US * CLK_MHZ;
   localparam int unsigned ERASE_CYC     = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W         = 20;

   // Array geometry
   localparam int unsigned ARRAY_BYTES = 8192;
   localparam int unsigned AW          = 13;
   localparam int unsigned PAGE_W      = 9;
   localparam logic [15:0] USER_TOP    = 16'h1dff;
   localparam logic [12:0] LOCK_ADDR   = 13'h1dff;
   localparam logic [3:0]  LOCK_PAGE   = 4'he;
   localparam logic [7:0]  ERASED      = 8'hff;

   // Key codes
   localparam logic [7:0] KEY_FIRST  = 8'ha5;
   localparam logic [7:0] KEY_SECOND = 8'hf1;

   // Register byte offsets and fields
   localparam logic [7:0] PSC_OFS  = 8'h00;
   localparam logic [7:0] KEY_OFS  = 8'h04;
   localparam logic [7:0] RSS_OFS  = 8'h08;
   localparam int unsigned PROGRAM_WRITE_ENABLE_BIT = 0;
   localparam int unsigned PAGE_ERASE_ENABLE_BIT = 1;
   localparam int unsigned MERR_BIT = 6;

   // Access kinds for the security check
   localparam logic [1:0] ACC_READ  = 2'h0;
   localparam logic [1:0] ACC_WRITE = 2'h1;
   localparam logic [1:0] ACC_ERASE = 2'h2;

   typedef enum logic [1:0] {
      KS_LOCKED = 2'b00,
      KS_FIRST  = 2'b01,
      KS_OPEN   = 2'b10,
      KS_DEAD   = 2'b11
   } fpe_key_e;

   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_PROG  = 2'b01,
      OP_ERASE = 2'b10
   } fpe_op_e;

endpackage
